/* pkg/fsb_arb_consts.svh */
// timing counts, reset values and widths of the arbitration logic
`ifndef FSB_ARB_CONSTS_SVH
`define FSB_ARB_CONSTS_SVH

`define AGENT_COUNT          4
`define AGENT_ID_W           2
`define ROT_ID_RESET         2'h3
`define BUSY_RESET           1'b0
`define CLK_PERIOD_NS        10
`define ADS_SPACING_CLKS     3
`define PRIO_RELEASE_CLKS    2
`define SPACING_CNT_W        2

`endif

/* pkg/fsb_arb_pkg.sv */
// types shared by the arbitration modules
package fsb_arb_pkg;
    typedef logic [1:0] agent_id_t;
    typedef logic [3:0] req_vec_t;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARB,
        ST_OWN,
        ST_GAP
    } req_state_t;
endpackage

/* pkg/arb_link_if.sv */
// signals between the agent core, the ownership tracker and the issue gate
interface arb_link_if;
    import fsb_arb_pkg::*;
    req_vec_t  req_obs;
    logic      reset_obs;
    agent_id_t my_id;
    agent_id_t rot_id;
    logic      busy;
    logic      own_next;
    logic      ads_seen;
    logic      prio_obs;
    logic      lock_held;
    logic      issue_ok;

    modport track (input req_obs, reset_obs, my_id, output rot_id, busy, own_next);
    modport gate  (input ads_seen, prio_obs, lock_held, reset_obs, output issue_ok);
    modport core  (output req_obs, reset_obs, my_id, ads_seen, prio_obs, lock_held,
                   input rot_id, busy, own_next, issue_ok);
endinterface

/* core/own_tracker.sv */
// shared rotating agent id and idle/busy ownership state, one copy per agent
`include "fsb_arb_consts.svh"
module own_tracker (
    input  wire logic  CLK,     // bus clock
    input  wire logic  RESETN,  // synchronous reset, active low
    arb_link_if.track  lnk      // observed lines in, ownership out
);
    import fsb_arb_pkg::*;

    agent_id_t rot_id_reg;
    agent_id_t rot_id_next;
    logic      busy_reg;
    logic      busy_next;
    logic      owner_rel;

    // round robin: the agent just after the rotating id wins first
    function automatic agent_id_t pick(input agent_id_t rid, input req_vec_t req);
        agent_id_t win;
        agent_id_t cand;
        win = rid;
        for (int k = `AGENT_COUNT; k >= 1; k--) begin
            cand = rid + agent_id_t'(k);
            if (req[cand])
                win = cand;
        end
        return win;
    endfunction

    assign owner_rel = !lnk.req_obs[rot_id_reg];

    always_comb begin
        rot_id_next = rot_id_reg;
        busy_next   = busy_reg;
        if (lnk.reset_obs) begin
            rot_id_next = `ROT_ID_RESET;                          // R22
            busy_next   = `BUSY_RESET;                            // R22
        end else if (!busy_reg && |lnk.req_obs) begin
            rot_id_next = pick(rot_id_reg, lnk.req_obs);          // R5 R6
            busy_next   = 1'b1;                                   // R6
        end else if (busy_reg && owner_rel) begin
            rot_id_next = pick(rot_id_reg, lnk.req_obs);          // R10
            busy_next   = |lnk.req_obs;                           // R10
        end
    end

    // every agent runs this on the same sampled lines, so copies agree
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            rot_id_reg <= `ROT_ID_RESET;
            busy_reg   <= `BUSY_RESET;
        end else begin
            rot_id_reg <= rot_id_next;                            // R1 R23
            busy_reg   <= busy_next;                              // R1 R23
        end
    end

    assign lnk.rot_id   = rot_id_reg;
    assign lnk.busy     = busy_reg;
    assign lnk.own_next = busy_next && (rot_id_next == lnk.my_id);
endmodule // own_tracker

/* core/issue_gate.sv */
// decides whether a request phase may start in the coming clock
`include "fsb_arb_consts.svh"
module issue_gate (
    input  wire logic  CLK,     // bus clock
    input  wire logic  RESETN,  // synchronous reset, active low
    arb_link_if.gate   lnk      // strobe and priority seen, verdict out
);
    import fsb_arb_pkg::*;

    logic [`SPACING_CNT_W-1:0] age_reg;

    // age of the last strobe, saturating at the spacing
    always_ff @(posedge CLK) begin
        if (!RESETN || lnk.reset_obs)
            age_reg <= `SPACING_CNT_W'(`ADS_SPACING_CLKS);
        else if (lnk.ads_seen)
            age_reg <= `SPACING_CNT_W'(1);
        else if (age_reg != `SPACING_CNT_W'(`ADS_SPACING_CLKS))
            age_reg <= age_reg + `SPACING_CNT_W'(1);
    end

    // priority observed one clock late lets one last strobe through,
    // and its release is seen one clock late, giving the two-clock gap
    assign lnk.issue_ok = !lnk.ads_seen
        && (age_reg >= `SPACING_CNT_W'(`ADS_SPACING_CLKS - 1))     // R8 R17
        && (!lnk.prio_obs || lnk.lock_held);                       // R13 R14 R21
endmodule // issue_gate

/* core/sym_agent_arb.sv */
// symmetric agent arbitration: request line, ownership, strobe and lock
// Overview of operation
// (R1) Without priority request or lock, ownership follows rotating id and idle/busy state.
// (R2) A winner hands the bus on after one transaction unless locked.
// (R3) After releasing, an agent may re-request one clock later.
// (R4) Own request line stays asserted through the strobe clock; with others waiting the code drops it in the strobe clock.
// (R5) Rotating id 3 and idle gives priority order 0,1,2,3.
// (R6) Requests sampled one clock late; winner and busy state set next clock.
// (R7) Priority request never changes symmetric arbitration or the rotating id.
// (R8) Request strobes on the bus are at least three clocks apart.
// (R9) Owner seeing other requests drops its line in its strobe clock.
// (R10) Owner release with others waiting hands over, id updates, stays busy.
// (R11) Owner with no competitors may park by holding its request line.
// (R12) A raised request line stays up until ownership is gained.
// (R13) One unlocked strobe may still follow a fresh priority request.
// (R14) After seeing the priority request, no new unlocked strobe starts.
// (R15) Priority agent starts four clocks after its request, three after last.
// (R16) Strobe only in a clock where this agent owns the bus.
// (R17) Priority release lets the owner resume, still keeping strobe spacing.
// (R18) During a locked sequence, hold request and lock, yield to nobody.
// (R19) Priority agent holds its request through its own strobe clock.
// (R20) Lock drops after the last locked transaction; priority may then start.
// (R21) Owner waits two clocks after priority release before a strobe.
// (R22) Bus reset sets rotating id to three and state to idle.
// (R23) Each agent keeps an identical copy of id and ownership state.
`include "fsb_arb_consts.svh"
module sym_agent_arb (
    input  wire logic                  CLK,          // bus clock, 100 MHz
    input  wire logic                  RESETN,       // synchronous reset, active low
    input  wire fsb_arb_pkg::agent_id_t AGENT_ID,    // this agent's id strap
    input  wire fsb_arb_pkg::req_vec_t  SYM_REQ_IN,  // symmetric request lines, high = active
    input  wire logic                  PRIO_REQ_IN,  // priority agent request, high = active
    input  wire logic                  ADS_IN,       // request-phase strobe seen on bus
    input  wire logic                  BUS_INIT_IN,  // bus reset or init event, high = active
    input  wire logic                  TXN_VALID,    // a transaction is pending
    input  wire logic                  TXN_LOCK,     // pending transaction is part of a lock
    input  wire logic                  LOCK_END,     // pulse: locked sequence completed
    input  wire logic                  PARK_ENABLE,  // keep ownership when nothing pending
    output logic                       SYM_REQ_OUT,  // own symmetric request line
    output logic                       ADS_OUT,      // own request-phase strobe
    output logic                       LOCK_OUT,     // lock signal drive
    output logic                       TXN_TAKEN,    // pulse: pending transaction issued
    output logic                       OWNER,        // this agent owns the bus
    output fsb_arb_pkg::agent_id_t     ROT_ID,       // rotating agent id copy
    output logic                       BUSY          // ownership state, high = busy
);
    import fsb_arb_pkg::*;

    arb_link_if lnk ();

    req_state_t st_reg;
    req_state_t st_next;
    agent_id_t  my_id_reg;
    req_vec_t   req_obs_reg;
    logic       prio_obs_reg;
    logic       init_obs_reg;
    logic       req_reg;
    logic       req_next;
    logic       ads_reg;
    logic       ads_next;
    logic       lock_reg;
    logic       lock_next;
    logic       own_reg;
    logic       others_obs;
    logic       lock_hold;
    logic       issue;
    logic       release_now;

    // strap taken while reset is held, so AGENT_ID is ignored once reset ends
    always_ff @(posedge CLK) begin
        if (!RESETN)
            my_id_reg <= AGENT_ID;
    end

    // request, priority and init lines are looked at one clock after they are driven; ADS_IN is used at once
    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            req_obs_reg  <= 4'h0;
            prio_obs_reg <= 1'b0;
            init_obs_reg <= 1'b0;
        end else begin
            req_obs_reg  <= SYM_REQ_IN;                           // R6
            prio_obs_reg <= PRIO_REQ_IN;
            init_obs_reg <= BUS_INIT_IN;
        end
    end

    assign lnk.req_obs   = req_obs_reg;
    assign lnk.reset_obs = init_obs_reg;
    assign lnk.my_id     = my_id_reg;
    assign lnk.ads_seen  = ADS_IN || ads_reg;
    assign lnk.prio_obs  = prio_obs_reg;
    assign lnk.lock_held = lock_reg;

    own_tracker u_track (
        .CLK    (CLK),
        .RESETN (RESETN),
        .lnk    (lnk)
    );

    issue_gate u_gate (
        .CLK    (CLK),
        .RESETN (RESETN),
        .lnk    (lnk)
    );

    // the priority request feeds the gate and the issue term, never the tracker
    assign others_obs = |(req_obs_reg & ~(req_vec_t'(1) << my_id_reg));  // R7

    // an open lock pins the bus unless the sequence ends this clock
    assign lock_hold = lock_reg && !LOCK_END;                     // R18

    // strobe in the next clock only while owning it then
    assign issue = (st_reg == ST_OWN) && TXN_VALID && lnk.own_next   // R16
        && lnk.issue_ok && !init_obs_reg
        && (!lnk.prio_obs || lock_reg || !TXN_LOCK || lock_reg);

    // give the bus back: after one strobe if others wait, or when idle unless parked with nobody waiting
    always_comb begin
        release_now = 1'b0;
        if (st_reg == ST_OWN && !lock_hold && !(issue && TXN_LOCK)) begin
            if (issue)
                release_now = others_obs;                         // R2 R9
            else if (!TXN_VALID)
                release_now = others_obs || !PARK_ENABLE;         // R11
        end
    end

    always_comb begin
        st_next  = st_reg;
        req_next = req_reg;
        unique case (st_reg)
            ST_IDLE: begin
                if (TXN_VALID) begin
                    st_next  = ST_ARB;
                    req_next = 1'b1;
                end
            end
            ST_ARB: begin
                req_next = 1'b1;                                  // R12
                if (lnk.own_next)
                    st_next = ST_OWN;
            end
            ST_OWN: begin
                if (release_now) begin
                    st_next  = ST_GAP;
                    req_next = 1'b0;                              // R9 R4
                end else begin
                    req_next = 1'b1;                              // R4 R11 R18
                end
            end
            ST_GAP: begin
                // line low for one clock, then up again only if a transaction is pending
                st_next  = TXN_VALID ? ST_ARB : ST_IDLE;          // R3
                req_next = TXN_VALID;                             // R3
            end
        endcase
        if (init_obs_reg) begin
            st_next  = ST_IDLE;
            req_next = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RESETN) begin
            st_reg  <= ST_IDLE;
            req_reg <= 1'b0;
        end else begin
            st_reg  <= st_next;
            req_reg <= req_next;
        end
    end

    // one strobe clock per transaction
    assign ads_next = issue;                                      // R8 R16

    always_ff @(posedge CLK) begin
        if (!RESETN)
            ads_reg <= 1'b0;
        else
            ads_reg <= ads_next;
    end

    // lock rises with the first locked strobe, falls after completion
    always_comb begin
        lock_next = lock_reg;
        if (init_obs_reg)
            lock_next = 1'b0;
        else if (lock_reg && LOCK_END)
            lock_next = 1'b0;                                     // R20
        else if (issue && TXN_LOCK)
            lock_next = 1'b1;                                     // R18
    end

    always_ff @(posedge CLK) begin
        if (!RESETN)
            lock_reg <= 1'b0;
        else
            lock_reg <= lock_next;
    end

    always_ff @(posedge CLK) begin
        if (!RESETN)
            own_reg <= 1'b0;
        else
            own_reg <= lnk.own_next && !init_obs_reg;
    end

    assign SYM_REQ_OUT = req_reg;
    assign ADS_OUT     = ads_reg;
    assign TXN_TAKEN   = ads_reg;
    assign LOCK_OUT    = lock_reg;
    assign OWNER       = own_reg;
    assign ROT_ID      = lnk.rot_id;
    assign BUSY        = lnk.busy;
endmodule // sym_agent_arb

/* verif/sym_agent_arb_checker.sv */
// port-level assertions for the symmetric agent arbitration block
`include "fsb_arb_consts.svh"
module sym_agent_arb_checker (
    input wire logic       CLK,          // clock
    input wire logic       RESETN,       // reset
    input wire logic [1:0] AGENT_ID,     // strap
    input wire logic [3:0] SYM_REQ_IN,   // lines
    input wire logic       PRIO_REQ_IN,  // priority
    input wire logic       ADS_IN,       // bus strobe
    input wire logic       BUS_INIT_IN,  // init
    input wire logic       LOCK_END,     // lock done
    input wire logic       SYM_REQ_OUT,  // own line
    input wire logic       ADS_OUT,      // own strobe
    input wire logic       LOCK_OUT,     // lock
    input wire logic       OWNER,        // owner
    input wire logic [1:0] ROT_ID,       // rotating id
    input wire logic       BUSY          // busy
);
    import fsb_arb_pkg::*;
    default clocking dc @(posedge CLK);
    endclocking
    default disable iff (!RESETN);

    // requester just after rot wins, rot itself last
    function automatic agent_id_t rr_win(agent_id_t rot, req_vec_t req);
        agent_id_t a;
        rr_win = rot;
        for (int i = 4; i > 0; i--) begin
            a = rot + agent_id_t'(i);
            if (req[a]) rr_win = a;
        end
    endfunction

    // an init now or one clock back would land in the middle of the check
    sequence idle_event;
        !BUSY && SYM_REQ_IN != 4'h0 && $past(SYM_REQ_IN) == 4'h0
            && !BUS_INIT_IN && !$past(BUS_INIT_IN);
    endsequence
    sequence owner_drop;
        BUSY && !SYM_REQ_IN[ROT_ID] && $past(SYM_REQ_IN[ROT_ID]) && !$past(BUS_INIT_IN)
            && !BUS_INIT_IN && (SYM_REQ_IN & ~(4'h1 << ROT_ID)) != 4'h0;
    endsequence
    sequence win_lands;
        ##2 BUSY && ROT_ID == rr_win($past(ROT_ID, 2), $past(SYM_REQ_IN, 2));
    endsequence

    idle_arb_a:
        assert property (idle_event |-> win_lands) else $error("idle winner wrong");
    hand_over_a:
        assert property (owner_drop |-> win_lands) else $error("handover winner wrong");
    ads_spacing_a:
        assert property (ADS_OUT |-> !$past(ADS_IN) && !$past(ADS_IN, 2))
        else $error("strobes too close");
    ads_owner_a:
        assert property (ADS_OUT |-> OWNER && BUSY && ROT_ID == AGENT_ID)
        else $error("strobe without ownership");
    prio_block_a:
        assert property (ADS_OUT |-> !$past(PRIO_REQ_IN, 2) || $past(LOCK_OUT))
        else $error("strobe under priority");
    lock_hold_a:
        assert property (LOCK_OUT && !LOCK_END && !$past(BUS_INIT_IN) |=> LOCK_OUT && SYM_REQ_OUT)
        else $error("lock not held");
    lock_end_a:
        assert property (LOCK_END && LOCK_OUT |=> !LOCK_OUT) else $error("lock not released");
    bus_init_a:
        assert property (BUS_INIT_IN |-> ##2 ROT_ID == `ROT_ID_RESET && BUSY == `BUSY_RESET
            && !SYM_REQ_OUT && !LOCK_OUT) else $error("init state wrong");
endmodule // sym_agent_arb_checker

bind sym_agent_arb sym_agent_arb_checker sym_agent_arb_checker_inst (.*);

/* verif/bus_peers.sv */
// far side of the bus: three peer agents and the priority agent
module bus_peers (
    input  wire logic       clk,        // clock
    input  wire logic       resetn,     // reset
    input  wire logic [1:0] own_id,     // block id
    input  wire logic       own_req,    // block line
    input  wire logic       own_ads,    // block strobe
    input  wire logic       lock_line,  // lock
    input  wire logic [1:0] rot_id,     // owner id
    input  wire logic       busy,       // busy
    input  wire logic [3:0] want,       // peers want
    input  wire logic       prio_want,  // priority wants
    output logic [3:0]      req_lines,  // all lines
    output logic            ads_line,   // bus strobe
    output logic            prio_line   // priority line
);
    import fsb_arb_pkg::*;
    req_vec_t   hold_reg;
    logic [2:0] prio_cnt;
    logic       prio_ads;
    logic       lock_seen;
    logic       ads_d;

    // peers never issue, so they drop the line as soon as they own
    always_ff @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            if (!resetn)
                hold_reg[i] <= 1'b0;
            else if (want[i])
                hold_reg[i] <= 1'b1;
            else if (busy && rot_id == agent_id_t'(i))
                hold_reg[i] <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            prio_line <= 1'b0;
            prio_cnt  <= 3'h0;
            prio_ads  <= 1'b0;
            lock_seen <= 1'b0;
            ads_d     <= 1'b0;
        end else begin
            prio_ads  <= 1'b0;
            // lock is seen one clock late; the strobe is checked both now and one clock back
            lock_seen <= lock_line;
            ads_d     <= ads_line;
            if (prio_ads)
                prio_line <= 1'b0;
            else if (prio_want && !prio_line) begin
                prio_line <= 1'b1;
                prio_cnt  <= 3'h1;
            end else if (prio_line && prio_cnt != 3'h4)
                prio_cnt <= prio_cnt + 3'h1;
            else if (prio_line && !lock_seen && !ads_line && !ads_d)
                prio_ads <= 1'b1;
        end
    end

    assign req_lines = (hold_reg & ~(4'h1 << own_id)) | (req_vec_t'(own_req) << own_id);
    assign ads_line  = own_ads | prio_ads;
endmodule // bus_peers

/* verif/sym_agent_arb_tb.sv */
// self-checking bench for the symmetric agent arbitration block
module sym_agent_arb_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fsb_arb_pkg::*;
    logic      clk, resetn, bus_init, txn_valid, txn_lock, lock_end, park, prio_want;
    logic      sym_req, ads, lock, taken, owner, busy, prio_line, ads_line;
    req_vec_t  req_lines, peer_want;
    agent_id_t rot_id;
    int        failures = 0;
    int        n_tests = 0;
    int        cycles = 0;

    sym_agent_arb sym_agent_arb_inst (
        .CLK(clk), .RESETN(resetn), .AGENT_ID(2'h0), .SYM_REQ_IN(req_lines),
        .PRIO_REQ_IN(prio_line), .ADS_IN(ads_line), .BUS_INIT_IN(bus_init),
        .TXN_VALID(txn_valid), .TXN_LOCK(txn_lock), .LOCK_END(lock_end),
        .PARK_ENABLE(park), .SYM_REQ_OUT(sym_req), .ADS_OUT(ads), .LOCK_OUT(lock),
        .TXN_TAKEN(taken), .OWNER(owner), .ROT_ID(rot_id), .BUSY(busy));
    bus_peers bus_peers_inst (
        .clk(clk), .resetn(resetn), .own_id(2'h0), .own_req(sym_req), .own_ads(ads),
        .lock_line(lock), .rot_id(rot_id), .busy(busy), .want(peer_want),
        .prio_want(prio_want), .req_lines(req_lines), .ads_line(ads_line),
        .prio_line(prio_line));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_taken;
        int i;
        i = 0;
        while (taken !== 1'b1 && i < 20) begin
            tick();
            i++;
        end
        check({3'h0, taken}, 4'h1);
    endtask

    task automatic results;
        $display("checks %0d, mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic t_rotate;
        park = 1'b1;
        txn_valid = 1'b1;
        peer_want = 4'h2;
        tick();
        peer_want = 4'h0;
        tick(3);
        check({2'h0, rot_id}, 4'h0);
        check({busy, owner, ads, sym_req}, 4'he);
        tick();
        check({3'h0, sym_req}, 4'h1);
        tick();
        check({1'b0, busy, rot_id}, 4'h5);
        wait_taken();
        check({2'h0, rot_id}, 4'h0);
        txn_valid = 1'b0;
        tick(4);
        check({1'b0, busy, owner, sym_req}, 4'h7);
        park = 1'b0;
        tick(4);
        check({busy, owner, rot_id}, 4'h0);
        $display("test rotate done");
    endtask

    task automatic t_prio;
        int k;
        park = 1'b1;
        txn_valid = 1'b1;
        wait_taken();
        txn_valid = 1'b0;
        prio_want = 1'b1;
        tick();
        prio_want = 1'b0;
        tick();
        txn_valid = 1'b1;
        k = 0;
        while (ads_line !== 1'b1 && k < 9) begin
            tick();
            k++;
        end
        check(4'(k), 4'h3);
        check({taken, busy, rot_id}, 4'h4);
        k = 0;
        while (taken !== 1'b1 && k < 9) begin
            tick();
            k++;
        end
        check(4'(k), 4'h3);
        txn_valid = 1'b0;
        $display("test prio done");
    endtask

    task automatic t_lock;
        txn_valid = 1'b1;
        txn_lock = 1'b1;
        tick();
        wait_taken();
        check({3'h0, lock}, 4'h1);
        peer_want = 4'h4;
        prio_want = 1'b1;
        tick();
        peer_want = 4'h0;
        prio_want = 1'b0;
        wait_taken();
        check({lock, sym_req, rot_id}, 4'hc);
        txn_valid = 1'b0;
        txn_lock = 1'b0;
        lock_end = 1'b1;
        tick();
        lock_end = 1'b0;
        check({2'h0, lock, sym_req}, 4'h0);
        tick();
        check({3'h0, ads_line}, 4'h0);
        tick();
        check({3'h0, ads_line}, 4'h1);
        check({1'b0, busy, rot_id}, 4'h6);
        $display("test lock done");
    endtask

    task automatic t_init;
        bus_init = 1'b1;
        tick();
        bus_init = 1'b0;
        tick();
        check({busy, sym_req, rot_id}, 4'h3);
        $display("test init done");
    endtask

    // a hung handshake would otherwise stall the run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 300) begin
            failures++;
            results();
        end
    end

    initial begin
        {resetn, bus_init, txn_valid, txn_lock, lock_end, park, prio_want} = 7'h0;
        peer_want = 4'h0;
        tick(2);
        resetn = 1'b1;
        tick();
        check({busy, sym_req, rot_id}, 4'h3);
        t_rotate();
        t_prio();
        t_lock();
        t_init();
        results();
    end
endmodule // sym_agent_arb_tb
